//--- src/cmwl_filter.sv
// bus state filter: a state counts only once held past the filter time
`timescale 1ns/10ps
`default_nettype none
module cmwl_filter #(
	parameter int WIDTH = 8, // counter width
	parameter int LIMIT = 72 // filter time in cycles
) (
	input wire logic clock_i, // system clock
	input wire logic rst_n_i, // synchronised reset, active low
	input wire logic clear_i, // back to recessive, count zero
	input wire logic dom_i, // bus above dominant threshold
	input wire logic rec_i, // bus below recessive threshold
	output logic qual_dom_o, // pulse: dominant became filtered
	output logic qual_rec_o, // pulse: recessive became filtered
	output logic held_dom_o // level: filtered dominant still present
);
	logic state_dom; // last clear state seen was dominant
	logic [WIDTH-1:0] cnt; // cycles held in that state
	wire logic same = state_dom ? dom_i : rec_i; // state still present
	wire logic grow = same && (cnt < WIDTH'(LIMIT)); // still counting

	// undefined band neither grows nor restarts the count
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_dom <= 1'b0;
			cnt <= '0;
		end else if (clear_i) begin
			state_dom <= 1'b0;
			cnt <= '0;
		end else if (dom_i && !state_dom) begin
			state_dom <= 1'b1;
			cnt <= '0;
		end else if (rec_i && state_dom) begin
			state_dom <= 1'b0;
			cnt <= '0;
		end else if (grow) begin
			cnt <= cnt + 1'b1;
		end
	end

	wire logic hit = grow && (cnt == WIDTH'(LIMIT - 1)); // just passed limit
	assign qual_dom_o = hit && state_dom && !clear_i;
	assign qual_rec_o = hit && !state_dom && !clear_i;
	assign held_dom_o = state_dom && dom_i && (cnt == WIDTH'(LIMIT));
endmodule // cmwl_filter
`default_nettype wire

//--- src/cmwl_pkg.sv
// constants shared by the transceiver mode and wake logic
package cmwl_pkg;
	localparam int CLK_PERIOD_NS = 25; // 40 mhz time base
	// wake filter: one 2 us bit at 500 kbps must pass, so stay under it
	localparam int WAKE_FILTER_NS = 1800;
	localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_WINDOW_US = 1000; // longest pattern time, rounds down
	localparam int WAKE_WINDOW_CYC = (WAKE_WINDOW_US * 1000) / CLK_PERIOD_NS;
	localparam int MODE_SETTLE_US = 200; // least settle time, rounds up
	localparam int MODE_SETTLE_CYC = (MODE_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DOM_TIMEOUT_US = 1200; // dominant timeout, rounds up
	localparam int DOM_TIMEOUT_CYC = (DOM_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_WIDTH = 16;
	localparam int DIFF_WIDTH = 13;
	// differential thresholds in millivolts
	localparam logic signed [12:0] NORM_DOM_MV = 13'sh384; // 900 mv
	localparam logic signed [12:0] NORM_REC_MV = 13'sh1f4; // 500 mv
	localparam logic signed [12:0] LP_DOM_MV = 13'sh47e; // 1150 mv
	localparam logic signed [12:0] LP_REC_MV = 13'sh190; // 400 mv
	localparam bit DUAL_SUPPLY_DEF = 1'b1; // io supply variant by default
	typedef enum logic [1:0] {M_PROT, M_SETTLE, M_NORMAL, M_STANDBY} cmwl_mode_type;
	typedef enum logic [1:0] {W_IDLE, W_DOM1, W_REC, W_WOKE} cmwl_wake_type;
endpackage

//--- src/cmwl_timer.sv
// saturating cycle timer used for settle, window and dominant timeout
`timescale 1ns/10ps
`default_nettype none
module cmwl_timer #(
	parameter int WIDTH = 16, // counter width
	parameter int LIMIT = 8 // cycles until done
) (
	input wire logic clock_i, // system clock
	input wire logic rst_n_i, // synchronised reset, active low
	input wire logic clear_i, // restart from zero
	input wire logic run_i, // count this cycle
	output logic done_o // limit reached, level
);
	logic [WIDTH-1:0] cnt; // elapsed cycles

	// stops at the limit so done stays up until cleared
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= '0;
		end else if (clear_i) begin
			cnt <= '0;
		end else if (run_i && !done_o) begin
			cnt <= cnt + 1'b1;
		end
	end

	assign done_o = (cnt >= WIDTH'(LIMIT));
endmodule // cmwl_timer
`default_nettype wire

//--- src/cmwl_top.sv
// mode control, fail-safe inputs and remote wake monitor of the transceiver
// Summary of operation
// - supply undervoltage gives protected state, bus undriven
// - supplies good: drive per tx, rx mirrors bus
// - dual supply, main low: standby_sel picks standby/protected
// - wait settle time after undervoltage before normal
// - open tx is recessive, open standby_sel standby
// - standby: driver off, rx high until wake
// - normal: tx low dominant, high recessive
// - normal: receiver on, rx follows bus
// - standby: bus undriven, weakly pulled to ground
// - wake monitor runs on io supply only
// - wake pattern: dominant, recessive, dominant, all filtered
// - unfiltered activity never resets pattern progress
// - wake on second dominant; later dominants pull rx
// - wake shows as rx low for dominant duration
// - state filtered only when held past filter time
// - filter passes 500 kbps bit in either state
// - pattern must finish within window, else restart
// - normal thresholds 0.9 v and 0.5 v; open high
// - standby thresholds 1.15 v and 0.4 v
// - dominant timeout disables driver until tx recessive
// - overtemperature disables driver, receive path stays
`timescale 1ns/10ps
`default_nettype none
module cmwl_top import cmwl_pkg::*; #(
	parameter bit DUAL_SUPPLY = DUAL_SUPPLY_DEF, // io supply variant present
	parameter int WINDOW_CYC = WAKE_WINDOW_CYC, // wake window in cycles
	parameter int SETTLE_CYC = MODE_SETTLE_CYC, // mode settle in cycles
	parameter int DTO_CYC = DOM_TIMEOUT_CYC // dominant timeout in cycles
) (
	input wire logic clock_i, // 40 mhz clock
	input wire logic rst_n_i, // async reset, active low
	input wire logic main_uv_i, // main supply below main_uv_thresh
	input wire logic io_uv_i, // io_supply below io_uv_thresh
	input wire logic overtemp_i, // overtemp_shutdown active
	input wire logic tx_in_i, // transmit data, low is dominant
	input wire logic tx_open_i, // tx_in pin floating
	input wire logic standby_sel_i, // high selects standby
	input wire logic standby_open_i, // standby_sel pin floating
	input wire logic signed [DIFF_WIDTH-1:0] bus_diff_mv_i, // bus_diff_voltage, mv
	input wire logic bus_open_i, // bus lines open
	output logic canh_o, // canh drive level
	output logic canh_oe_n_o, // canh enable, low while driven
	output logic canl_o, // canl drive level
	output logic canl_oe_n_o, // canl enable, low while driven
	output logic bias_mid_o, // recessive bias to half supply
	output logic bias_gnd_o, // weak pull of bus to ground
	output logic rx_out_o, // receive data to controller
	output logic rx_out_oe_n_o, // rx enable, low while driven
	output logic normal_o, // device in normal mode
	output logic dto_fault_o // dominant timeout active
);
	logic rst_meta; // first reset stage
	logic rst_n; // synchronised reset
	cmwl_mode_type mode; // operating mode
	cmwl_mode_type next_mode; // mode next cycle
	cmwl_wake_type wk; // wake monitor state
	cmwl_wake_type next_wk; // wake state next cycle
	logic tx_prev; // last effective tx level
	logic dto_armed; // falling tx edge seen in normal
	logic main_lost; // standby held on io supply only

	// reset is released through two flops
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// fail-safe bias of floating logic pins
	wire logic tx_eff = tx_open_i | tx_in_i;
	wire logic stb_eff = standby_open_i | standby_sel_i;

	// supply decoding
	wire logic uv_block = main_uv_i | (DUAL_SUPPLY & io_uv_i);
	wire logic stby_uv = DUAL_SUPPLY & main_uv_i & ~io_uv_i & stb_eff;
	wire logic rx_hiz = DUAL_SUPPLY ? io_uv_i : main_uv_i;

	// receiver classification, normal and low-power thresholds
	wire logic norm_dom = !bus_open_i && (bus_diff_mv_i >= NORM_DOM_MV);
	wire logic norm_rec = bus_open_i || (bus_diff_mv_i <= NORM_REC_MV);
	wire logic lp_dom = !bus_open_i && (bus_diff_mv_i >= LP_DOM_MV);
	wire logic lp_rec = bus_open_i || (bus_diff_mv_i <= LP_REC_MV);

	// timers, each a plain cycle count
	logic settle_done; // settle time over
	logic win_done; // wake window expired
	logic dto_done; // tx held dominant too long
	cmwl_timer #(.WIDTH(TIMER_WIDTH), .LIMIT(SETTLE_CYC)) u_settle (
		.clock_i(clock_i),
		.rst_n_i(rst_n),
		.clear_i(mode != M_SETTLE),
		.run_i(1'b1),
		.done_o(settle_done)
	);
	wire logic win_run = (wk == W_DOM1) || (wk == W_REC); // pattern under way
	cmwl_timer #(.WIDTH(TIMER_WIDTH), .LIMIT(WINDOW_CYC)) u_window (
		.clock_i(clock_i),
		.rst_n_i(rst_n),
		.clear_i(!win_run),
		.run_i(1'b1),
		.done_o(win_done)
	);
	cmwl_timer #(.WIDTH(TIMER_WIDTH), .LIMIT(DTO_CYC)) u_dto (
		.clock_i(clock_i),
		.rst_n_i(rst_n),
		.clear_i(!dto_armed),
		.run_i(1'b1),
		.done_o(dto_done)
	);

	// low-power bus filter only runs in standby
	logic qual_dom; // filtered dominant pulse
	logic qual_rec; // filtered recessive pulse
	logic held_dom; // filtered dominant level
	cmwl_filter #(.WIDTH(8), .LIMIT(WAKE_FILTER_CYC)) u_filter (
		.clock_i(clock_i),
		.rst_n_i(rst_n),
		.clear_i(mode != M_STANDBY),
		.dom_i(lp_dom),
		.rec_i(lp_rec),
		.qual_dom_o(qual_dom),
		.qual_rec_o(qual_rec),
		.held_dom_o(held_dom)
	);

	// mode selection; undervoltage outranks the mode pin
	always_comb begin
		next_mode = mode;
		if (stby_uv) begin
			next_mode = M_STANDBY;
		end else if (uv_block) begin
			next_mode = M_PROT;
		end else begin
			unique case (mode)
				M_PROT: begin
					next_mode = M_SETTLE;
				end
				M_SETTLE: begin
					if (settle_done) begin
						next_mode = stb_eff ? M_STANDBY : M_NORMAL;
					end
				end
				M_NORMAL: begin
					if (stb_eff) begin
						next_mode = M_STANDBY;
					end
				end
				M_STANDBY: begin
					// supply came back under standby: settle first
					if (!stb_eff) begin
						next_mode = main_lost ? M_SETTLE : M_NORMAL;
					end
				end
			endcase
		end
	end

	// wake monitor; a late pattern loses to the window
	always_comb begin
		next_wk = wk;
		if (mode != M_STANDBY) begin
			next_wk = W_IDLE;
		end else begin
			unique case (wk)
				W_IDLE: begin
					if (qual_dom) begin
						next_wk = W_DOM1;
					end
				end
				W_DOM1: begin
					if (win_done) begin
						next_wk = W_IDLE;
					end else if (qual_rec) begin
						next_wk = W_REC;
					end
				end
				W_REC: begin
					if (win_done) begin
						next_wk = W_IDLE;
					end else if (qual_dom) begin
						next_wk = W_WOKE;
					end
				end
				W_WOKE: begin
					next_wk = W_WOKE; // held until standby mode is left
				end
			endcase
		end
	end

	// state registers
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			mode <= M_PROT;
			wk <= W_IDLE;
		end else begin
			mode <= next_mode;
			wk <= next_wk;
		end
	end

	// dominant timeout arms only on a falling tx edge in normal mode
	wire logic tx_fall = tx_prev && !tx_eff;
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_prev <= 1'b1;
			dto_armed <= 1'b0;
			main_lost <= 1'b0;
		end else begin
			tx_prev <= tx_eff;
			if (mode != M_NORMAL || tx_eff) begin
				dto_armed <= 1'b0;
			end else if (tx_fall) begin
				dto_armed <= 1'b1;
			end
			if (stby_uv) begin
				main_lost <= 1'b1;
			end else if (mode != M_STANDBY) begin
				main_lost <= 1'b0;
			end
		end
	end

	// output decode
	wire logic drv_en = (mode == M_NORMAL) && !dto_done && !overtemp_i;
	wire logic drv_dom = drv_en && !tx_eff;
	wire logic rx_norm = norm_dom ? 1'b0 : (norm_rec ? 1'b1 : rx_out_o);
	// the qualifying dominant itself already shows on rx, so the wake edge is not late
	// by a cycle; before the pattern completes rx stays high
	wire logic woke_now = (wk == W_WOKE) || (next_wk == W_WOKE);
	wire logic rx_stby = woke_now ? !(held_dom || qual_dom) : 1'b1;
	wire logic rx_next = (mode == M_NORMAL) ? rx_norm : ((mode == M_STANDBY) ? rx_stby : 1'b1);

	// registered pin drive; undriven lines have enable high
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			canh_o <= 1'b0;
			canl_o <= 1'b1;
			canh_oe_n_o <= 1'b1;
			canl_oe_n_o <= 1'b1;
			bias_mid_o <= 1'b0;
			bias_gnd_o <= 1'b0;
			rx_out_o <= 1'b1;
			rx_out_oe_n_o <= 1'b1;
			normal_o <= 1'b0;
			dto_fault_o <= 1'b0;
		end else begin
			canh_o <= 1'b1;
			canl_o <= 1'b0;
			canh_oe_n_o <= !drv_dom;
			canl_oe_n_o <= !drv_dom;
			bias_mid_o <= (mode == M_NORMAL);
			bias_gnd_o <= (mode == M_STANDBY);
			rx_out_o <= rx_next;
			rx_out_oe_n_o <= rx_hiz;
			normal_o <= (mode == M_NORMAL);
			dto_fault_o <= dto_done;
		end
	end

	// checks
	uv_prot_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		main_uv_i || io_uv_i |-> ##2 canh_oe_n_o && canl_oe_n_o)
		else $error("bus driven under undervoltage");
	settle_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		mode == M_SETTLE && !settle_done |=> mode != M_NORMAL)
		else $error("normal entered before settle time");
	dto_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		dto_done |=> canh_oe_n_o && dto_fault_o)
		else $error("driver active after dominant timeout");
	dto_arm_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		mode == M_NORMAL && !dto_armed && !tx_fall |=> !dto_armed)
		else $error("timeout armed without falling edge");
	tsd_off_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		overtemp_i |=> canh_oe_n_o && canl_oe_n_o)
		else $error("driver active in overtemperature");
	stby_rx_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		mode == M_STANDBY && wk != W_WOKE && next_wk != W_WOKE |=> rx_out_o)
		else $error("rx low in standby before wake");
	stby_bias_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		mode == M_STANDBY |=> bias_gnd_o && canh_oe_n_o && canl_oe_n_o)
		else $error("standby bus not floating to ground");
	wake_seq_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		wk == W_REC && !qual_dom |=> wk != W_WOKE)
		else $error("wake without second filtered dominant");
	wake_rx_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		mode == M_STANDBY && wk == W_REC && qual_dom && !win_done && !stby_uv && stb_eff |=> !rx_out_o)
		else $error("wake not shown on rx");
	window_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		win_done && (wk == W_DOM1 || wk == W_REC) |=> wk == W_IDLE)
		else $error("pattern kept past window");
	norm_rx_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		mode == M_NORMAL && norm_dom |=> !rx_out_o)
		else $error("rx high on dominant bus");
	open_rx_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		mode == M_NORMAL && bus_open_i |=> rx_out_o)
		else $error("rx low on open bus");
	clear_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		mode == M_NORMAL |=> wk == W_IDLE)
		else $error("wake state kept in normal mode");

	// mode, pin and monitor checks
	rx_hiz_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		rx_hiz |=> rx_out_oe_n_o)
		else $error("rx driven without io supply");
	prot_rx_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		mode == M_PROT |=> rx_out_o)
		else $error("rx not recessive in protected state");
	stby_uv_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		stby_uv |=> mode == M_STANDBY)
		else $error("standby lost on io supply only");
	drv_dom_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		drv_dom |=> !canh_oe_n_o && !canl_oe_n_o)
		else $error("dominant not driven");
	bias_mid_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		mode == M_NORMAL |=> bias_mid_o && !bias_gnd_o)
		else $error("normal bias missing");
	dto_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		tx_eff |=> !dto_armed)
		else $error("timeout kept with tx recessive");
	wake_idle_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		mode == M_STANDBY && wk == W_IDLE && !qual_dom |=> wk == W_IDLE)
		else $error("pattern started without filtered dominant");
	wake_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		mode == M_STANDBY && wk == W_DOM1 && !win_done && !qual_rec |=> wk == W_DOM1)
		else $error("pattern progress lost");
	filt_dom_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		qual_dom |-> lp_dom && mode == M_STANDBY)
		else $error("dominant qualified without bus dominant");
	norm_rec_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		mode == M_NORMAL && norm_rec |=> rx_out_o)
		else $error("rx low on recessive bus");

	// cover points for the main scenarios
	wake_c: cover property (@(posedge clock_i) disable iff (!rst_n) wk == W_REC ##1 wk == W_WOKE);
	timeout_c: cover property (@(posedge clock_i) disable iff (!rst_n) win_done && wk == W_REC);
	dto_c: cover property (@(posedge clock_i) disable iff (!rst_n) dto_done && !tx_eff);
	settle_c: cover property (@(posedge clock_i) disable iff (!rst_n) mode == M_SETTLE ##1 mode == M_NORMAL);
endmodule // cmwl_top
`default_nettype wire

//--- test/can_transceiver_mode_wake_logic_tb.sv
// self-checking bench for the transceiver mode and wake logic
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end
module can_transceiver_mode_wake_logic_tb import cmwl_pkg::*;;
	localparam int WIN = 400; // short wake window for simulation
	localparam int SET = 20; // short settle time
	localparam int DTO = 100; // short dominant timeout
	logic clock, rst_n, main_uv, io_uv, overtemp, tx_open, stb_open, bus_open; // stimulus
	logic tx_req, stb_req, auto_wake; // controller model requests
	logic signed [DIFF_WIDTH-1:0] bus_mv; // differential bus level
	logic tx_in, stb_sel; // controller pins
	logic canh, canh_oe_n, canl, canl_oe_n, bias_mid, bias_gnd, rx, rx_oe_n, normal, dto; // outputs
	int n_mismatch, compares, cycles, k; // counters
	cmwl_top #(.WINDOW_CYC(WIN), .SETTLE_CYC(SET), .DTO_CYC(DTO)) dut_u (
		.clock_i(clock), .rst_n_i(rst_n), .main_uv_i(main_uv), .io_uv_i(io_uv),
		.overtemp_i(overtemp), .tx_in_i(tx_in), .tx_open_i(tx_open), .standby_sel_i(stb_sel),
		.standby_open_i(stb_open), .bus_diff_mv_i(bus_mv), .bus_open_i(bus_open),
		.canh_o(canh), .canh_oe_n_o(canh_oe_n), .canl_o(canl), .canl_oe_n_o(canl_oe_n),
		.bias_mid_o(bias_mid), .bias_gnd_o(bias_gnd), .rx_out_o(rx), .rx_out_oe_n_o(rx_oe_n),
		.normal_o(normal), .dto_fault_o(dto));
	cmwl_ctrl_model ctrl_u (.clock_i(clock), .rst_n_i(rst_n), .tx_req_i(tx_req), .stb_req_i(stb_req),
		.auto_wake_i(auto_wake), .rx_out_i(rx), .tx_in_o(tx_in), .standby_sel_o(stb_sel));
	// 40 mhz clock
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// cut a hang short; the whole run needs well under 3000 cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 6000) begin
			n_mismatch++;
			$display("Error timeout expected 0 seen 1");
			end_sim;
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	// hold one bus level for n cycles, changed on the falling edge
	task automatic bus(input int mv, input int n);
		bus_mv = DIFF_WIDTH'(mv);
		cyc(n);
	endtask
	// bounded wait for a receive level, cycle count in k
	task automatic wait_rx(input logic v);
		k = 0;
		while (rx !== v && k < 100) begin
			cyc(1);
			k++;
		end
	endtask
	task automatic wait_normal(input int lim);
		k = 0;
		while (normal !== 1'b1 && k < lim) begin
			cyc(1);
			k++;
		end
	endtask
	task automatic end_sim;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// floating pins after power-up, then normal on request
	task automatic t_open;
		cyc(SET + 12);
		`CHK("normal", 1'b0, normal)
		`CHK("bias_gnd", 1'b1, bias_gnd)
		`CHK("canh_oe_n", 1'b1, canh_oe_n)
		stb_open = 1'b0;
		cyc(3);
		`CHK("normal", 1'b1, normal)
		`CHK("bias_mid", 1'b1, bias_mid)
	endtask
	// driver table, receiver thresholds, overtemperature
	task automatic t_normal;
		tx_open = 1'b0;
		cyc(3);
		`CHK("canh_oe_n", 1'b0, canh_oe_n)
		`CHK("canl_oe_n", 1'b0, canl_oe_n)
		`CHK("canh", 1'b1, canh)
		`CHK("canl", 1'b0, canl)
		bus(900, 2);
		`CHK("rx", 1'b0, rx)
		bus(500, 2);
		`CHK("rx", 1'b1, rx)
		bus(901, 2);
		bus_open = 1'b1;
		cyc(2);
		`CHK("rx", 1'b1, rx)
		bus_open = 1'b0;
		overtemp = 1'b1;
		bus(900, 3);
		`CHK("canh_oe_n", 1'b1, canh_oe_n)
		`CHK("rx", 1'b0, rx)
		overtemp = 1'b0;
		tx_open = 1'b1;
		bus(0, 3);
		`CHK("canl_oe_n", 1'b1, canl_oe_n)
		tx_open = 1'b0;
		tx_req = 1'b1;
		cyc(3);
		`CHK("canh_oe_n", 1'b1, canh_oe_n)
	endtask
	// dominant timeout, receive path stays alive
	task automatic t_dto;
		tx_req = 1'b0;
		cyc(DTO - 5);
		`CHK("dto", 1'b0, dto)
		`CHK("canh_oe_n", 1'b0, canh_oe_n)
		bus(900, 10);
		`CHK("dto", 1'b1, dto)
		`CHK("canh_oe_n", 1'b1, canh_oe_n)
		`CHK("rx", 1'b0, rx)
		tx_req = 1'b1;
		bus(0, 3);
		`CHK("dto", 1'b0, dto)
		`CHK("rx", 1'b1, rx)
	endtask
	// undervoltage states and settle before normal
	task automatic t_uv;
		main_uv = 1'b1;
		bus(900, 3);
		`CHK("normal", 1'b0, normal)
		`CHK("canh_oe_n", 1'b1, canh_oe_n)
		`CHK("rx_oe_n", 1'b0, rx_oe_n)
		`CHK("rx", 1'b1, rx)
		stb_req = 1'b1;
		cyc(3);
		`CHK("bias_gnd", 1'b1, bias_gnd)
		io_uv = 1'b1;
		cyc(3);
		`CHK("rx_oe_n", 1'b1, rx_oe_n)
		io_uv = 1'b0;
		main_uv = 1'b0;
		stb_req = 1'b0;
		bus(0, SET - 5);
		`CHK("normal", 1'b0, normal)
		wait_normal(15);
		`CHK("normal", 1'b1, normal)
	endtask
	// wake pattern with a short glitch; the model answers the wake edge
	task automatic t_wake;
		stb_req = 1'b1;
		tx_req = 1'b0;
		cyc(3);
		`CHK("bias_gnd", 1'b1, bias_gnd)
		`CHK("canh_oe_n", 1'b1, canh_oe_n)
		bus(1150, 80);
		bus(400, 80);
		bus(1150, 20);
		bus(400, 80);
		`CHK("rx", 1'b1, rx)
		bus_mv = 13'sh47e;
		wait_rx(1'b0);
		`CHK("wake delay", 1'b1, k inside {[70:78]})
		cyc(20);
		`CHK("rx", 1'b0, rx)
		bus(400, 3);
		`CHK("rx", 1'b1, rx)
		auto_wake = 1'b1;
		tx_req = 1'b1;
		bus_mv = 13'sh47e;
		wait_rx(1'b0);
		`CHK("redo delay", 1'b1, k inside {[70:78]})
		wait_normal(10);
		`CHK("normal", 1'b1, normal)
		auto_wake = 1'b0;
		stb_req = 1'b0;
		bus(0, 3);
	endtask
	// a short dominant and a late pattern never wake; monitor restarted idle
	task automatic t_window;
		stb_req = 1'b1;
		bus(1150, 60);
		bus(400, 80);
		bus(1150, 80);
		bus(400, WIN + 50);
		bus(1150, 80);
		`CHK("rx", 1'b1, rx)
		`CHK("normal", 1'b0, normal)
		stb_req = 1'b0;
		bus(0, 3);
	endtask
	// main sequence
	initial begin
		{rst_n, main_uv, io_uv, overtemp, bus_open, tx_req, stb_req, auto_wake} = '0;
		{tx_open, stb_open} = 2'b11;
		bus_mv = '0;
		n_mismatch = 0;
		compares = 0;
		cycles = 0;
		cyc(16);
		rst_n = 1'b1;
		t_open;
		$display("open pins done");
		t_normal;
		$display("normal done");
		t_dto;
		$display("timeout done");
		t_uv;
		$display("undervoltage done");
		t_wake;
		$display("wake done");
		t_window;
		$display("window done");
		end_sim;
	end
endmodule // can_transceiver_mode_wake_logic_tb
`default_nettype wire

//--- test/cmwl_ctrl_model.sv
// protocol controller model facing the logic side of the transceiver
`timescale 1ns/10ps
`default_nettype none
module cmwl_ctrl_model (
	input wire logic clock_i, // system clock
	input wire logic rst_n_i, // reset, active low
	input wire logic tx_req_i, // transmit level asked by the bench
	input wire logic stb_req_i, // standby asked by the bench
	input wire logic auto_wake_i, // leave standby on a wake edge
	input wire logic rx_out_i, // receive data from the transceiver
	output logic tx_in_o, // transmit pin
	output logic standby_sel_o // standby select pin
);
	logic rx_q; // last receive level, for edge detect
	logic woke; // wake edge seen while asked for standby
	// watch for a high-to-low receive edge; cleared once standby is no longer asked
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_q <= 1'b1;
			woke <= 1'b0;
		end else begin
			rx_q <= rx_out_i;
			if (!stb_req_i) begin
				woke <= 1'b0;
			end else if (auto_wake_i && rx_q && !rx_out_i) begin
				woke <= 1'b1;
			end
		end
	end
	assign tx_in_o = tx_req_i; // transmit passes straight through
	assign standby_sel_o = stb_req_i & ~woke;
endmodule // cmwl_ctrl_model
`default_nettype wire
